// ### ra_defs.svh
`ifndef RA_DEFS_SVH
`define RA_DEFS_SVH
// Behaviour
// - inbound latch strobe loads 16 bus bits into two byte holding registers
// - drive number on three select lines, register number on five lines
// - write counts as transfer command only when register zero is addressed
// - external register write asserts controller-to-drive direction with the selects
// - command bits and write function held in control store, sent by command strobe
// - transfer start emits a 50 ns initialization pulse; the code holds it for three 20 ns cycles, 60 ns
// - function decoder enabled only for register zero with go bit set
// - bits 5..3: 111 read, 110 write, 101 write check
// - bits 2..1 both set means reverse, otherwise forward
// - store bits 7..5 pick drive, bits 4..0 pick register
// - valid function sets busy; busy refuses new transfer commands
// - demand requested for transfer command write only while not busy
// - demand request one-shot sets demand flip-flop driving demand line
// - write data held in latch; parity line high when ones count even
// - demand waits 250 ns after control data placed on lines
// - acknowledge drops demand and fires done pulse
// - no acknowledge within 1.5 us sets nonexistent drive, drops demand
// - attention write ignores acknowledge, waits 1.5 us plus 250 ns
// - attention register read uses no timeout
// - read leaves direction low; drive returns data and ack; parity checked
// - loopback mode never drives demand onto the bus

`define RA_CLK_NS       20
`define RA_T_INIT_NS    50
`define RA_T_SKEW_NS    250
`define RA_T_TIMEOUT_NS 1500
`define RA_INIT_CYC     ((`RA_T_INIT_NS + `RA_CLK_NS - 1) / `RA_CLK_NS)
`define RA_SKEW_CYC     ((`RA_T_SKEW_NS + `RA_CLK_NS - 1) / `RA_CLK_NS)
`define RA_TIMEOUT_CYC  ((`RA_T_TIMEOUT_NS + `RA_CLK_NS - 1) / `RA_CLK_NS)
`define RA_TIMER_W      8

`define RA_CTRL_REG     5'h00
`define RA_ATTN_REG     5'h04
`define RA_GO_BIT       0
`define RA_DIR_LO       1
`define RA_DIR_HI       2
`define RA_FN_LO        3
`define RA_FN_HI        5
`define RA_FN_READ      3'h7
`define RA_FN_WRITE     3'h6
`define RA_FN_WCHK      3'h5
`define RA_DRV_LO       5
`define RA_DRV_HI       7
`define RA_REG_HI       4
`endif

// ### ra_pkg.sv
package ra_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic wchk;
        logic rev;
    } ra_func_t;

    typedef struct packed {
        logic       write_function;
        logic [2:0] drive;
        logic [4:0] reg_sel;
    } ra_ctrl_store_t;

    typedef enum logic [2:0] {
        RA_IDLE,
        RA_SKEW,
        RA_WAIT,
        RA_ATTN_HOLD
    } ra_state_t;
endpackage

// ### ra_drive_register_access.sv
`include "ra_defs.svh"

module ra_drive_register_access #(
    parameter logic [4:0] ATTN_REG = `RA_ATTN_REG
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire logic              i_inbound_latch_strobe,
    input  wire logic [15:0]       i_bus_data,
    input  wire logic              i_ext_cmd_strobe,
    input  wire logic [7:0]        i_received_cmd_bits,
    input  wire logic              i_write_function,
    input  wire logic              i_loopback_mode,
    input  wire logic              i_transfer_end,
    input  wire logic              i_clear_flags,
    input  wire logic              i_transfer_ack,
    input  wire logic [15:0]       i_drive_data,
    input  wire logic              i_drive_parity,
    output logic [2:0]             o_drive_select_lines,
    output logic [4:0]             o_register_select_lines,
    output logic                   o_ctrl_to_drive_dir,
    output logic                   o_demand_out,
    output logic [15:0]            o_ctrl_data,
    output logic                   o_ctrl_data_oe,
    output logic                   o_parity_out,
    output logic                   o_nonexistent_drive_flag,
    output logic                   o_control_parity_error,
    output logic                   o_transfer_busy_flag,
    output logic                   o_transfer_init_pulse,
    output logic                   o_transfer_cmd_seen,
    output ra_pkg::ra_func_t       o_function,
    output logic                   o_cmd_refused,
    output logic                   o_done,
    output logic                   o_cycle_busy,
    output logic [15:0]            o_read_data
);
    localparam logic [`RA_TIMER_W-1:0] INIT_CYC = `RA_TIMER_W'(`RA_INIT_CYC);
    localparam logic [`RA_TIMER_W-1:0] SKEW_CYC = `RA_TIMER_W'(`RA_SKEW_CYC);
    localparam logic [`RA_TIMER_W-1:0] TO_CYC   = `RA_TIMER_W'(`RA_TIMEOUT_CYC);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic        ack_m_q, ack_s_q, par_m_q, par_s_q;
    logic [15:0] dat_m_q, dat_s_q;

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
            par_m_q <= 1'b0;
            par_s_q <= 1'b0;
            dat_m_q <= 16'h0000;
            dat_s_q <= 16'h0000;
        end else begin
            ack_m_q <= i_transfer_ack;
            ack_s_q <= ack_m_q;
            par_m_q <= i_drive_parity;
            par_s_q <= par_m_q;
            dat_m_q <= i_drive_data;
            dat_s_q <= dat_m_q;
        end
    end

    // ------------------------------------------------------------
    // inbound holding registers
    // ------------------------------------------------------------
    logic [7:0] hold_lo_q, hold_hi_q;

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_lo_q <= 8'h00;
            hold_hi_q <= 8'h00;
        end else if (i_inbound_latch_strobe) begin
            hold_lo_q <= i_bus_data[7:0];
            hold_hi_q <= i_bus_data[15:8];
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    ra_pkg::ra_state_t   state_q;
    ra_pkg::ra_func_t    func_d;
    logic                fn_valid, dec_en, is_xfer_cmd, start, accept_xfer;
    logic [7:0]          dec_out;
    logic [2:0]          fn_code;

    assign fn_code = hold_lo_q[`RA_FN_HI:`RA_FN_LO];
    assign dec_en  = i_write_function && (i_received_cmd_bits[`RA_REG_HI:0] == `RA_CTRL_REG)
                     && hold_lo_q[`RA_GO_BIT];

    always_comb begin
        dec_out = 8'h00;
        if (dec_en) begin
            dec_out[fn_code] = 1'b1;
        end
    end

    always_comb begin
        func_d.rd   = dec_out[`RA_FN_READ];
        func_d.wr   = dec_out[`RA_FN_WRITE];
        func_d.wchk = dec_out[`RA_FN_WCHK];
        func_d.rev  = &hold_lo_q[`RA_DIR_HI:`RA_DIR_LO];
    end

    assign fn_valid    = func_d.rd || func_d.wr || func_d.wchk;
    assign is_xfer_cmd = fn_valid;
    assign start       = i_ext_cmd_strobe && (state_q == ra_pkg::RA_IDLE);
    assign accept_xfer = start && is_xfer_cmd && !o_transfer_busy_flag;

    // ------------------------------------------------------------
    // control store and select lines
    // ------------------------------------------------------------
    ra_pkg::ra_ctrl_store_t cs_q;

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cs_q <= '0;
        end else if (start && !(is_xfer_cmd && o_transfer_busy_flag)) begin
            cs_q.write_function <= i_write_function;
            cs_q.drive          <= i_received_cmd_bits[`RA_DRV_HI:`RA_DRV_LO];
            cs_q.reg_sel        <= i_received_cmd_bits[`RA_REG_HI:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_drive_select_lines    <= 3'h0;
            o_register_select_lines <= 5'h00;
            o_ctrl_to_drive_dir     <= 1'b0;
        end else begin
            o_drive_select_lines    <= cs_q.drive;
            o_register_select_lines <= cs_q.reg_sel;
            o_ctrl_to_drive_dir     <= cs_q.write_function && (state_q != ra_pkg::RA_IDLE);
        end
    end

    // ------------------------------------------------------------
    // write data latch and parity
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ctrl_data    <= 16'h0000;
            o_parity_out   <= 1'b0;
            o_ctrl_data_oe <= 1'b0;
        end else begin
            if (start && i_write_function && !(is_xfer_cmd && o_transfer_busy_flag)) begin
                o_ctrl_data  <= {hold_hi_q, hold_lo_q};
                o_parity_out <= ~^{hold_hi_q, hold_lo_q};
            end
            o_ctrl_data_oe <= cs_q.write_function && (state_q != ra_pkg::RA_IDLE);
        end
    end

    // ------------------------------------------------------------
    // transfer busy, functions, init pulse
    // ------------------------------------------------------------
    logic [`RA_TIMER_W-1:0] init_cnt_q;

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_transfer_busy_flag <= 1'b0;
            o_function           <= '0;
            o_transfer_cmd_seen  <= 1'b0;
            o_cmd_refused        <= 1'b0;
        end else begin
            o_transfer_cmd_seen <= start && is_xfer_cmd;
            o_cmd_refused       <= start && is_xfer_cmd && o_transfer_busy_flag;
            if (accept_xfer) begin
                o_transfer_busy_flag <= 1'b1;
                o_function           <= func_d;
            end else if (i_transfer_end) begin
                o_transfer_busy_flag <= 1'b0;
                o_function           <= '0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            init_cnt_q            <= '0;
            o_transfer_init_pulse <= 1'b0;
        end else if (accept_xfer) begin
            init_cnt_q            <= INIT_CYC - `RA_TIMER_W'(1);
            o_transfer_init_pulse <= 1'b1;
        end else if (init_cnt_q != '0) begin
            init_cnt_q <= init_cnt_q - `RA_TIMER_W'(1);
        end else begin
            o_transfer_init_pulse <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control path cycle sequencer
    // ------------------------------------------------------------
    logic [`RA_TIMER_W-1:0] timer_q;
    logic                   demand_request_q, demand_q, finish, set_ned, take_read;
    logic                   attn_wr, attn_rd, timed_out;

    assign attn_wr   = cs_q.write_function && (cs_q.reg_sel == ATTN_REG);
    assign attn_rd   = !cs_q.write_function && (cs_q.reg_sel == ATTN_REG);
    assign timed_out = (timer_q == TO_CYC - `RA_TIMER_W'(1));

    always_comb begin
        finish    = 1'b0;
        set_ned   = 1'b0;
        take_read = 1'b0;
        case (state_q)
            ra_pkg::RA_WAIT: begin
                if (demand_q && !attn_wr && ack_s_q) begin
                    finish    = 1'b1;
                    take_read = !cs_q.write_function;
                end else if (demand_q && !attn_wr && !attn_rd && timed_out) begin
                    finish = 1'b1;
                    if (i_loopback_mode && !cs_q.write_function) begin
                        take_read = 1'b1;
                    end else begin
                        set_ned = 1'b1;
                    end
                end
            end
            ra_pkg::RA_ATTN_HOLD: begin
                finish = (timer_q == SKEW_CYC - `RA_TIMER_W'(1));
            end
            default: begin
                finish = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q          <= ra_pkg::RA_IDLE;
            timer_q          <= '0;
            demand_request_q <= 1'b0;
        end else begin
            demand_request_q <= 1'b0;
            case (state_q)
                ra_pkg::RA_IDLE: begin
                    timer_q <= '0;
                    if (start && !(is_xfer_cmd && o_transfer_busy_flag)) begin
                        state_q <= ra_pkg::RA_SKEW;
                    end
                end
                ra_pkg::RA_SKEW: begin
                    if (timer_q == SKEW_CYC - `RA_TIMER_W'(1)) begin
                        demand_request_q <= 1'b1;
                        timer_q          <= '0;
                        state_q          <= ra_pkg::RA_WAIT;
                    end else begin
                        timer_q <= timer_q + `RA_TIMER_W'(1);
                    end
                end
                ra_pkg::RA_WAIT: begin
                    if (finish) begin
                        state_q <= ra_pkg::RA_IDLE;
                    end else if (attn_wr && demand_q && timed_out) begin
                        timer_q <= '0;
                        state_q <= ra_pkg::RA_ATTN_HOLD;
                    end else if (demand_q && !timed_out) begin
                        timer_q <= timer_q + `RA_TIMER_W'(1);
                    end
                end
                ra_pkg::RA_ATTN_HOLD: begin
                    if (finish) begin
                        state_q <= ra_pkg::RA_IDLE;
                    end else begin
                        timer_q <= timer_q + `RA_TIMER_W'(1);
                    end
                end
                default: begin
                    state_q <= ra_pkg::RA_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // demand flip-flop and bus driver
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            demand_q     <= 1'b0;
            o_demand_out <= 1'b0;
            o_done       <= 1'b0;
            o_cycle_busy <= 1'b0;
        end else begin
            if (demand_request_q) begin
                demand_q <= 1'b1;
            end else if (finish) begin
                demand_q <= 1'b0;
            end
            o_demand_out <= (demand_request_q || (demand_q && !finish)) && !i_loopback_mode;
            o_done       <= finish;
            o_cycle_busy <= (state_q != ra_pkg::RA_IDLE) && !finish;
        end
    end

    // ------------------------------------------------------------
    // status flags and read data
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_nonexistent_drive_flag <= 1'b0;
            o_control_parity_error   <= 1'b0;
            o_read_data              <= 16'h0000;
        end else begin
            if (set_ned) begin
                o_nonexistent_drive_flag <= 1'b1;
            end else if (i_clear_flags) begin
                o_nonexistent_drive_flag <= 1'b0;
            end
            if (take_read && !(^{dat_s_q, par_s_q})) begin
                o_control_parity_error <= 1'b1;
            end else if (i_clear_flags) begin
                o_control_parity_error <= 1'b0;
            end
            if (take_read) begin
                o_read_data <= dat_s_q;
            end
        end
    end
endmodule

// ### ra_drive_register_access_checker.sv
module ra_drive_register_access_checker #(
    parameter logic [4:0] ATTN_REG = 5'h04
) (
    input wire logic             i_sys_clk,
    input wire logic             i_reset,
    input wire logic             i_transfer_ack,
    input wire logic             i_loopback_mode,
    input wire logic [4:0]       o_register_select_lines,
    input wire logic             o_ctrl_to_drive_dir,
    input wire logic             o_demand_out,
    input wire logic [15:0]      o_ctrl_data,
    input wire logic             o_ctrl_data_oe,
    input wire logic             o_parity_out,
    input wire logic             o_nonexistent_drive_flag,
    input wire logic             o_transfer_busy_flag,
    input wire logic             o_transfer_init_pulse,
    input wire logic             o_transfer_cmd_seen,
    input wire ra_pkg::ra_func_t o_function,
    input wire logic             o_done
);
    // ----------------------------------------
    // demand length counter
    // ----------------------------------------
    logic [7:0] dem_cnt_q;
    logic       attn_w;
    assign attn_w = (o_register_select_lines == ATTN_REG) && o_ctrl_to_drive_dir;
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            dem_cnt_q <= 8'h00;
        end else if (!o_demand_out) begin
            dem_cnt_q <= 8'h00;
        end else if (dem_cnt_q != 8'hff) begin
            dem_cnt_q <= dem_cnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    property p_loop; o_demand_out |-> !i_loopback_mode; endproperty
    a_loop: assert property (p_loop) else $error("demand in loopback");
    property p_par; o_ctrl_data_oe |-> o_parity_out == ~(^o_ctrl_data); endproperty
    a_par: assert property (p_par) else $error("parity line wrong");
    property p_skew; $rose(o_demand_out) && o_ctrl_to_drive_dir |-> $past(o_ctrl_data_oe, 12); endproperty
    a_skew: assert property (p_skew) else $error("demand before skew delay");
    property p_ack;
        o_demand_out && i_transfer_ack && o_register_select_lines != ATTN_REG |-> ##[1:5] (o_done && !o_demand_out);
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not end cycle");
    property p_tmo; o_ctrl_to_drive_dir && !attn_w |-> dem_cnt_q <= 8'd80; endproperty
    a_tmo: assert property (p_tmo) else $error("write demand too long");
    property p_ned; $rose(o_nonexistent_drive_flag) |-> $past(dem_cnt_q) >= 8'd70 && !attn_w; endproperty
    a_ned: assert property (p_ned) else $error("nonexistent flag early");
    property p_attn; $fell(o_demand_out) && $past(attn_w) |-> $past(dem_cnt_q) >= 8'd85; endproperty
    a_attn: assert property (p_attn) else $error("attention write ended early");
    property p_init; $rose(o_transfer_init_pulse) |-> o_transfer_init_pulse[*3] ##1 !o_transfer_init_pulse; endproperty
    a_init: assert property (p_init) else $error("init pulse length");
    property p_busy; o_transfer_cmd_seen |-> ##[0:2] o_transfer_busy_flag; endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_rst;
        $fell(i_reset) |-> !o_transfer_busy_flag && !o_demand_out && !o_nonexistent_drive_flag && o_function == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("flags not cleared by reset");
endmodule

bind ra_drive_register_access ra_drive_register_access_checker #(.ATTN_REG(ATTN_REG)) u_chk (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_transfer_ack(i_transfer_ack), .i_loopback_mode(i_loopback_mode),
    .o_register_select_lines(o_register_select_lines), .o_ctrl_to_drive_dir(o_ctrl_to_drive_dir),
    .o_demand_out(o_demand_out), .o_ctrl_data(o_ctrl_data), .o_ctrl_data_oe(o_ctrl_data_oe),
    .o_parity_out(o_parity_out), .o_nonexistent_drive_flag(o_nonexistent_drive_flag),
    .o_transfer_busy_flag(o_transfer_busy_flag), .o_transfer_init_pulse(o_transfer_init_pulse),
    .o_transfer_cmd_seen(o_transfer_cmd_seen), .o_function(o_function), .o_done(o_done));

// ### ra_drive_model.sv
module ra_drive_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_present,
    input  wire logic        i_bad_par,
    input  wire logic [7:0]  i_ack_delay,
    input  wire logic        i_demand,
    input  wire logic        i_dir,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_ctrl_data,
    output logic             o_ack,
    output logic [15:0]      o_data,
    output logic             o_parity
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // drive register file and handshake
    // ----------------------------------------
    logic [15:0] mem [0:255];
    logic [7:0]  cnt_q;
    initial begin
        o_ack = 1'b0;
        o_data = 16'h0000;
        o_parity = 1'b0;
        cnt_q = 8'h00;
    end
    always @(posedge i_sys_clk) begin
        if (!i_demand) begin
            cnt_q <= 8'h00;
            o_ack <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            if (i_present && i_dir && cnt_q == 8'h00) begin
                mem[i_addr] <= i_ctrl_data;
            end
            if (i_present && cnt_q == i_ack_delay) begin
                o_ack <= 1'b1;
            end
        end
    end
    always @(posedge i_sys_clk) begin
        if (i_present && i_demand && !i_dir) begin
            o_data <= mem[i_addr];
            o_parity <= ~(^mem[i_addr]) ^ i_bad_par;
        end else begin
            o_data <= ~o_data;
            o_parity <= ~o_parity;
        end
    end
endmodule

// ### ra_drive_register_access_tb_top.sv
module ra_drive_register_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, latch, cmd, wrf, loop_m, t_end, clr, present, bad_par;
    logic dir, demand_strobe, nonexistent_drive_flag, perr, busy, refused, done, ack, dpar, cbusy;
    logic [15:0] bus_data, cdata, rdata, ddata, tdat;
    logic [7:0]  cmd_bits, delay;
    logic [2:0]  sel_drv;
    logic [4:0]  sel_reg;
    ra_pkg::ra_func_t fn;
    int failures, total_checks, cycles;
    ra_drive_register_access i_dut (.i_sys_clk(clk), .i_reset(rst), .i_inbound_latch_strobe(latch),
        .i_bus_data(bus_data), .i_ext_cmd_strobe(cmd), .i_received_cmd_bits(cmd_bits), .i_write_function(wrf),
        .i_loopback_mode(loop_m), .i_transfer_end(t_end), .i_clear_flags(clr), .i_transfer_ack(ack),
        .i_drive_data(ddata), .i_drive_parity(dpar), .o_drive_select_lines(sel_drv),
        .o_register_select_lines(sel_reg), .o_ctrl_to_drive_dir(dir), .o_demand_out(demand_strobe), .o_ctrl_data(cdata),
        .o_ctrl_data_oe(), .o_parity_out(), .o_nonexistent_drive_flag(nonexistent_drive_flag), .o_control_parity_error(perr),
        .o_transfer_busy_flag(busy), .o_transfer_init_pulse(), .o_transfer_cmd_seen(), .o_function(fn),
        .o_cmd_refused(refused), .o_done(done), .o_cycle_busy(cbusy), .o_read_data(rdata));
    ra_drive_model i_drive (.i_sys_clk(clk), .i_present(present), .i_bad_par(bad_par), .i_ack_delay(delay),
        .i_demand(demand_strobe), .i_dir(dir), .i_addr({sel_drv, sel_reg}), .i_ctrl_data(cdata), .o_ack(ack),
        .o_data(ddata), .o_parity(dpar));
    // ----------------------------------------
    // clock, timeout and tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic which);
        @(posedge clk);
        clr   <= which;
        t_end <= !which;
        @(posedge clk);
        clr   <= 1'b0;
        t_end <= 1'b0;
        @(posedge clk);
    endtask
    task automatic access(input logic w, input logic [7:0] addr, input logic [15:0] d, input logic want_done);
        int   n;
        logic hit;
        @(posedge clk);
        latch <= 1'b1;
        bus_data <= d;
        @(posedge clk);
        latch <= 1'b0;
        cmd <= 1'b1;
        cmd_bits <= addr;
        wrf <= w;
        @(posedge clk);
        cmd <= 1'b0;
        n = 0;
        hit = 1'b0;
        while ((want_done ? done : refused) !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
            hit = hit | cbusy;
        end
        chk(16'(n < 300), 16'h0001);
        chk({hit, cbusy}, {want_done, 1'b0});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {rst, latch, cmd, wrf, loop_m, t_end, clr, bad_par} = 8'h80;
        present = 1'b1;
        bus_data = 16'h0000;
        cmd_bits = 8'h00;
        delay = 8'h0d;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({busy, nonexistent_drive_flag, demand_strobe}, 16'h0000);
        access(1'b1, {3'h5, 5'h03}, 16'h1234, 1'b1);
        chk(i_drive.mem[8'ha3], 16'h1234);
        chk({sel_drv, sel_reg}, 16'h00a3);
        chk(nonexistent_drive_flag, 1'b0);
        access(1'b0, {3'h5, 5'h03}, 16'h0000, 1'b1);
        chk(rdata, 16'h1234);
        chk(perr, 1'b0);
        delay <= 8'h28;
        access(1'b1, {3'h2, 5'h07}, 16'h00ff, 1'b1);
        chk(i_drive.mem[8'h47], 16'h00ff);
        bad_par <= 1'b1;
        access(1'b0, {3'h2, 5'h07}, 16'h0000, 1'b1);
        chk(perr, 1'b1);
        bad_par <= 1'b0;
        present <= 1'b0;
        access(1'b1, {3'h6, 5'h01}, 16'h5555, 1'b1);
        chk(nonexistent_drive_flag, 1'b1);
        pulse(1'b1);
        chk({nonexistent_drive_flag, perr}, 16'h0000);
        present <= 1'b1;
        delay <= 8'h0d;
        access(1'b1, {3'h1, i_dut.ATTN_REG}, 16'h0003, 1'b1);
        chk(nonexistent_drive_flag, 1'b0);
        delay <= 8'h5a;
        access(1'b0, {3'h1, i_dut.ATTN_REG}, 16'h0000, 1'b1);
        chk(rdata, 16'h0003);
        chk(nonexistent_drive_flag, 1'b0);
        delay <= 8'h0d;
        loop_m <= 1'b1;
        access(1'b0, {3'h4, 5'h02}, 16'h0000, 1'b1);
        chk(nonexistent_drive_flag, 1'b0);
        loop_m <= 1'b0;
        for (int f = 5; f <= 7; f++) begin
            for (int v = 1; v <= 3; v += 2) begin
                tdat = {10'h000, 3'(f), 2'(v), 1'b1};
                access(1'b1, 8'h00, tdat, 1'b1);
                chk(fn, {f == 7, f == 6, f == 5, v == 3});
                chk(busy, 1'b1);
                access(1'b1, 8'h00, tdat ^ 16'h0002, 1'b0);
                chk(fn, {f == 7, f == 6, f == 5, v == 3});
                pulse(1'b0);
                chk(busy, 1'b0);
            end
        end
        access(1'b1, 8'h00, 16'h0038, 1'b1);
        chk({busy, 11'h000, fn}, 16'h0000);
        access(1'b1, 8'h00, 16'h0021, 1'b1);
        chk({busy, 11'h000, fn}, 16'h0000);
        access(1'b1, 8'h61, 16'h0039, 1'b1);
        chk({busy, 11'h000, fn}, 16'h0000);
        access(1'b1, 8'h00, 16'h0039, 1'b1);
        chk(busy, 1'b1);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({busy, nonexistent_drive_flag, demand_strobe, 9'h000, fn}, 16'h0000);
        give_verdict();
    end
endmodule
